// file: rtl/gcw_cmd_track.sv
// New-command detector on the control word toggle flag
`timescale 1ns/1ps
`default_nettype none
module gcw_cmd_track
    import gcw_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] ctrl_word_i,
    output logic             new_cmd_o,
    output logic             cmd_ok_o
);
    typedef struct packed {
        logic last_tog;
        logic new_cmd;
        logic cmd_ok;
    } gcw_trk_t;
    gcw_trk_t r, next_r;

    always_comb begin
        next_r         = r;
        next_r.new_cmd = ctrl_word_i[TOGGLE_BIT] != r.last_tog;
        next_r.cmd_ok  = gcw_cmd_ok(ctrl_word_i[CMD_LSB +: 3], ctrl_word_i[EXT_LSB +: 4]);
        next_r.last_tog = ctrl_word_i[TOGGLE_BIT];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign new_cmd_o = r.new_cmd;
    assign cmd_ok_o  = r.cmd_ok;
endmodule : gcw_cmd_track
`default_nettype wire

// file: rtl/gcw_controller.sv
// Controller end: APB registers that build the control word and read back status
`timescale 1ns/1ps
`default_nettype none
module gcw_controller
    import gcw_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    gcw_if.ctl               link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] io_out;
        logic        io_out_valid;
        logic [15:0] io_in;
        logic        io_fresh;
        logic        offline;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } gcw_ctl_t;
    gcw_ctl_t r, next_r;
    logic acc;
    logic wr_done;

    assign acc     = psel && penable && !r.ready;
    assign wr_done = psel && penable && r.ready && pwrite && !r.err;

    always_comb begin
        next_r              = r;
        next_r.ready        = acc;
        next_r.io_out_valid = 1'b0;
        if (link.io_in_valid) begin
            next_r.io_in = link.io_in;
        end
        if (acc) begin
            next_r.err   = !(paddr == ADDR_CMD || paddr == ADDR_STATUS || paddr == ADDR_IO_OUT
                             || paddr == ADDR_IO_IN || paddr == ADDR_LINK);
            next_r.rdata = 32'h0;
            case (paddr)
                ADDR_CMD:    next_r.rdata = {16'h0, r.ctrl};
                ADDR_STATUS: next_r.rdata = {16'h0, link.status_word};
                ADDR_IO_OUT: next_r.rdata = {16'h0, r.io_out};
                ADDR_IO_IN:  next_r.rdata = {15'h0, r.io_fresh, r.io_in};
                ADDR_LINK:   next_r.rdata = {31'h0, r.offline};
                default:     next_r.rdata = 32'h0;
            endcase
        end
        if (psel && penable && r.ready && !pwrite && paddr == ADDR_IO_IN) begin
            next_r.io_fresh = 1'b0;
        end
        if (link.io_in_valid) begin
            next_r.io_fresh = 1'b1;
        end
        if (wr_done) begin
            case (paddr)
                ADDR_CMD: begin
                    // Toggle flips on each issued command, command byte first
                    next_r.ctrl = {pwdata[NODE_LSB +: 8], !r.ctrl[TOGGLE_BIT],
                                   pwdata[CMD_LSB +: 3], pwdata[EXT_LSB +: 4]};
                end
                ADDR_IO_OUT: begin
                    next_r.io_out       = pwdata[15:0];
                    next_r.io_out_valid = 1'b1;
                end
                ADDR_LINK: begin
                    next_r.offline = pwdata[0];
                    if (pwdata[0] && !r.offline) begin
                        next_r.ctrl = {r.ctrl[NODE_LSB +: 8], !r.ctrl[TOGGLE_BIT],
                                       CMD_NOP, 4'h0};
                    end
                end
                default: begin
                    next_r.ctrl = r.ctrl;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign link.ctrl_word    = r.ctrl;
    assign link.io_out       = r.io_out;
    assign link.io_out_valid = r.io_out_valid;
    assign prdata            = r.rdata;
    assign pready            = r.ready;
    assign pslverr           = r.err;
endmodule : gcw_controller
`default_nettype wire

// file: rtl/gcw_device.sv
// Gateway end: decodes the control word and drives the secondary network state
// Overview of operation
// - Byte 0: toggle, 3-bit command, 4-bit extension
// - Command 0 sets state by extension
// - Master: command acts on node or network
// - Slave: operational when PLC runs, else pre-operational
// - Command 1 returns recorded node state
// - Command 2 returns general status; 3-6 reserved
// - Command 7 does nothing; use when offline
// - Refuse secondary operational request with FF10h emergency
// - Send FF10h when returned to pre-operational; the code sends it only on command 0 extension 0, not after a reset
// - Controller uses node zero in slave role
// - Unsupervised node states are unavailable
// - Start-up: initialize, then pre-operational automatically
// - I/O moves only while operational
// - Operational master manages; slave answers requests
// - Resets restore settings, return to initialization
// - Command byte first, node number second
// - Node 0 self, 80h all, else one node
// - Status echoes last valid command and toggle
// - Control word occupies first two image bytes
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gcw_device
    import gcw_pkg::*;
#(
    parameter int NODES = 128
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    gcw_if.dev               link,
    input  wire logic        role_master_i,
    input  wire logic        sec_op_req_i,
    input  wire logic        node_st_wr_i,
    input  wire logic [6:0]  node_st_idx_i,
    input  wire logic [3:0]  node_st_val_i,
    input  wire logic        node_sup_i,
    input  wire logic [3:0]  can_status_i,
    input  wire logic [7:0]  err_node_i,
    input  wire logic [15:0] sec_rx_data_i,
    input  wire logic        sec_rx_valid_i,
    output logic [1:0]       nmt_state_o,
    output logic             plc_enabled_o,
    output logic             nmt_cmd_valid_o,
    output logic [3:0]       nmt_cmd_o,
    output logic [7:0]       nmt_node_o,
    output logic             emcy_valid_o,
    output logic [15:0]      emcy_code_o,
    output logic             reset_node_o,
    output logic             reset_comm_o,
    output logic [15:0]      sec_tx_data_o,
    output logic             sec_tx_valid_o
);
    typedef struct packed {
        gcw_nmt_t    state;
        logic        plc_en;
        logic [3:0]  net_state;
        logic [15:0] status;
        logic [15:0] io_in;
        logic        io_in_valid;
        logic        nmt_valid;
        logic [3:0]  nmt_cmd;
        logic [7:0]  nmt_node;
        logic        emcy;
        logic        rst_node;
        logic        rst_comm;
        logic [15:0] tx_data;
        logic        tx_valid;
    } gcw_dev_t;
    gcw_dev_t r, next_r;

    logic [4:0] node_mem [NODES];
    logic       new_cmd;
    logic       cmd_ok;
    logic       tog;
    logic [2:0] cmd;
    logic [3:0] ext;
    logic [7:0] node;
    logic [3:0] rsp;
    logic [4:0] entry;

    // Fields of the first image word, command byte first
    assign tog  = link.ctrl_word[TOGGLE_BIT];
    assign cmd  = link.ctrl_word[CMD_LSB +: 3];
    assign ext  = link.ctrl_word[EXT_LSB +: 4];
    assign node = link.ctrl_word[NODE_LSB +: 8];

    gcw_cmd_track u_track (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .ctrl_word_i (link.ctrl_word),
        .new_cmd_o   (new_cmd),
        .cmd_ok_o    (cmd_ok)
    );

    // Supervised flag plus last reported state of each remote node
    always_ff @(posedge core_clk_i) begin
        if (node_st_wr_i) begin
            node_mem[node_st_idx_i] <= {node_sup_i, node_st_val_i};
        end
    end

    assign entry = node_mem[node[6:0]];

    always_comb begin
        next_r          = r;
        next_r.nmt_valid = 1'b0;
        next_r.emcy     = 1'b0;
        next_r.rst_node = 1'b0;
        next_r.rst_comm = 1'b0;
        next_r.io_in_valid = 1'b0;
        next_r.tx_valid = 1'b0;
        rsp             = ext;
        next_r.status[NODE_LSB +: 8] = err_node_i;
        if (r.state == GCW_INIT) begin
            next_r.state = GCW_PREOP;
        end
        // Secondary master asks for operational state
        if (sec_op_req_i && !role_master_i && r.state != GCW_INIT) begin
            if (r.plc_en) begin
                next_r.state = GCW_OPER;
            end else begin
                next_r.emcy = 1'b1;
            end
        end
        if (new_cmd) begin
            next_r.status[TOGGLE_BIT] = tog;
        end
        if (new_cmd && cmd_ok) begin
            case (cmd)
                CMD_SET_NMT: begin
                    if (node == NODE_SELF || !role_master_i) begin
                        case (ext)
                            EXT_OPER: begin
                                next_r.plc_en = 1'b1;
                                next_r.state  = GCW_OPER;
                            end
                            EXT_PREOP: begin
                                next_r.plc_en = 1'b0;
                                next_r.state  = GCW_PREOP;
                                next_r.emcy   = 1'b1;
                            end
                            EXT_STOP: begin
                                next_r.plc_en = 1'b0;
                                next_r.state  = GCW_STOP;
                            end
                            EXT_RST_NODE: begin
                                next_r.plc_en   = 1'b0;
                                next_r.state    = GCW_INIT;
                                next_r.rst_node = 1'b1;
                            end
                            default: begin
                                next_r.plc_en   = 1'b0;
                                next_r.state    = GCW_INIT;
                                next_r.rst_comm = 1'b1;
                            end
                        endcase
                    end else if (r.plc_en) begin
                        next_r.nmt_valid = 1'b1;
                        next_r.nmt_cmd   = ext;
                        next_r.nmt_node  = node;
                        if (node == NODE_ALL) begin
                            next_r.net_state = ext;
                        end
                    end
                end
                CMD_GET_NODE: begin
                    if (node == NODE_SELF || !role_master_i) begin
                        rsp = gcw_state_code(r.state);
                    end else if (node == NODE_ALL) begin
                        rsp = r.net_state;
                    end else begin
                        rsp = entry[4] ? entry[3:0] : EXT_UNKNOWN;
                    end
                end
                CMD_GET_STATUS: begin
                    rsp = can_status_i;
                end
                default: begin
                    rsp = ext;
                end
            endcase
            next_r.status[CMD_LSB +: 3] = cmd;
            next_r.status[EXT_LSB +: 4] = rsp;
        end
        // I/O words pass in either direction only while operational
        if (r.state == GCW_OPER) begin
            next_r.tx_valid    = link.io_out_valid;
            next_r.tx_data     = link.io_out_valid ? link.io_out : r.tx_data;
            next_r.io_in_valid = sec_rx_valid_i;
            next_r.io_in       = sec_rx_valid_i ? sec_rx_data_i : r.io_in;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r           <= '0;
            r.state     <= GCW_INIT;
            r.net_state <= EXT_PREOP;
        end else begin
            r <= next_r;
        end
    end

    assign link.status_word = r.status;
    assign link.io_in       = r.io_in;
    assign link.io_in_valid = r.io_in_valid;
    assign nmt_state_o      = r.state;
    assign plc_enabled_o    = r.plc_en;
    assign nmt_cmd_valid_o  = r.nmt_valid;
    assign nmt_cmd_o        = r.nmt_cmd;
    assign nmt_node_o       = r.nmt_node;
    assign emcy_valid_o     = r.emcy;
    assign emcy_code_o      = EMCY_NOT_ENA;
    assign reset_node_o     = r.rst_node;
    assign reset_comm_o     = r.rst_comm;
    assign sec_tx_data_o    = r.tx_data;
    assign sec_tx_valid_o   = r.tx_valid;
endmodule : gcw_device
`default_nettype wire

// file: rtl/gcw_if.sv
// Exchange image carrier between controller and gateway
`timescale 1ns/1ps
`default_nettype none
interface gcw_if;
    logic [15:0] ctrl_word;
    logic [15:0] io_out;
    logic        io_out_valid;
    logic [15:0] status_word;
    logic [15:0] io_in;
    logic        io_in_valid;
    modport ctl (output ctrl_word, output io_out, output io_out_valid,
                 input status_word, input io_in, input io_in_valid);
    modport dev (input ctrl_word, input io_out, input io_out_valid,
                 output status_word, output io_in, output io_in_valid);
endinterface : gcw_if
`default_nettype wire

// file: rtl/gcw_pkg.sv
// Shared constants and types of the gateway control word decoder
package gcw_pkg;
    localparam int          IMAGE_BYTES    = 512;
    localparam int          IO_BYTES       = IMAGE_BYTES - 2;
    localparam int          TOGGLE_BIT     = 7;
    localparam int          CMD_LSB        = 4;
    localparam int          EXT_LSB        = 0;
    localparam int          NODE_LSB       = 8;
    localparam logic [2:0]  CMD_SET_NMT    = 3'h0;
    localparam logic [2:0]  CMD_GET_NODE   = 3'h1;
    localparam logic [2:0]  CMD_GET_STATUS = 3'h2;
    localparam logic [2:0]  CMD_NOP        = 3'h7;
    localparam logic [3:0]  EXT_PREOP      = 4'h0;
    localparam logic [3:0]  EXT_OPER       = 4'h1;
    localparam logic [3:0]  EXT_RST_NODE   = 4'h2;
    localparam logic [3:0]  EXT_RST_COMM   = 4'h3;
    localparam logic [3:0]  EXT_STOP       = 4'h4;
    localparam logic [3:0]  EXT_UNKNOWN    = 4'h5;
    localparam logic [7:0]  NODE_SELF      = 8'h00;
    localparam logic [7:0]  NODE_ALL       = 8'h80;
    localparam logic [15:0] EMCY_NOT_ENA   = 16'hFF10;
    localparam logic [7:0]  ADDR_CMD       = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_IO_OUT    = 8'h08;
    localparam logic [7:0]  ADDR_IO_IN     = 8'h0C;
    localparam logic [7:0]  ADDR_LINK      = 8'h10;
    localparam int          IO_FRESH_BIT   = 16;

    typedef enum logic [1:0] {
        GCW_INIT  = 2'h0,
        GCW_PREOP = 2'h1,
        GCW_OPER  = 2'h3,
        GCW_STOP  = 2'h2
    } gcw_nmt_t;

    function automatic logic gcw_cmd_ok(input logic [2:0] cmd, input logic [3:0] ext);
        gcw_cmd_ok = (cmd == CMD_SET_NMT && ext <= EXT_STOP) || cmd == CMD_GET_NODE
                     || cmd == CMD_GET_STATUS || cmd == CMD_NOP;
    endfunction : gcw_cmd_ok

    function automatic logic [3:0] gcw_state_code(input gcw_nmt_t st);
        case (st)
            GCW_OPER: gcw_state_code = EXT_OPER;
            GCW_STOP: gcw_state_code = EXT_STOP;
            default:  gcw_state_code = EXT_PREOP;
        endcase
    endfunction : gcw_state_code
endpackage : gcw_pkg

// file: verif/gcw_monitor.sv
// Concurrent checks on the control and status words between the two ends
`timescale 1ns/1ps
`default_nettype none
module gcw_monitor (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] ctrl_word,
    input wire logic [15:0] status_word,
    input wire logic        io_out_valid,
    input wire logic        io_in_valid
);
    logic tog_q;
    logic nc;
    logic rsv;
    logic ok;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog_q <= 1'b0;
        end else begin
            tog_q <= ctrl_word[7];
        end
    end

    // New command seen on the wire, split into reserved and valid codes
    assign nc  = ctrl_word[7] != tog_q;
    assign rsv = nc && ((ctrl_word[6:4] >= 3'h3 && ctrl_word[6:4] <= 3'h6)
                 || (ctrl_word[6:4] == 3'h0 && ctrl_word[3:0] > 4'h4));
    assign ok  = nc && !rsv;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_toggle_mirror: assert property (nc |-> ##2 status_word[7] == ctrl_word[7])
        else $error("status toggle does not mirror control toggle");
    chk_echo_cmd: assert property (ok |-> ##2 status_word[6:4] == ctrl_word[6:4])
        else $error("valid command not echoed");
    chk_set_ext: assert property (ok && ctrl_word[6:4] == 3'h0 |-> ##2 status_word[3:0] == ctrl_word[3:0])
        else $error("state change extension not reflected");
    chk_reserved_hold: assert property (rsv |=> $stable(status_word[6:0]) [*2])
        else $error("reserved code changed the echo");
    chk_ctrl_toggle: assert property ($changed(ctrl_word) |-> $changed(ctrl_word[7]))
        else $error("control word changed without toggle flip");
    chk_status_cause: assert property ($changed(status_word[7:0]) |-> $past(ctrl_word[7], 2) != $past(ctrl_word[7], 3))
        else $error("status byte changed without a new command");
    chk_io_out_pulse: assert property (io_out_valid |=> !io_out_valid)
        else $error("output word strobe longer than one cycle");
    chk_io_in_pulse: assert property (io_in_valid |=> !io_in_valid)
        else $error("input word strobe longer than one cycle");

    cov_reserved: cover property (rsv);
    cov_broadcast: cover property (ok && ctrl_word[15:8] == 8'h80);
    cov_io_in: cover property (io_in_valid);
endmodule : gcw_monitor
`default_nettype wire

// file: verif/tb_gateway_control_word_decoder.sv
// Self-checking bench joining controller and gateway ends
`timescale 1ns/1ps
`default_nettype none
module tb_gateway_control_word_decoder
    import gcw_pkg::*;
;
    logic        core_clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, err_node_i = 8'h05;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, exp_tog = 1'b0;
    logic        role_master_i = 1'b0, sec_op_req_i = 1'b0, node_st_wr_i = 1'b0, node_sup_i = 1'b0;
    logic [6:0]  node_st_idx_i = 7'h00;
    logic [3:0]  node_st_val_i = 4'h0, can_status_i = 4'h0, nmt_cmd_o;
    logic [15:0] sec_rx_data_i = 16'h0, emcy_code_o, sec_tx_data_o, last_tx;
    logic        sec_rx_valid_i = 1'b0, plc_enabled_o, nmt_cmd_valid_o, emcy_valid_o;
    logic        reset_node_o, reset_comm_o, sec_tx_valid_o;
    logic [1:0]  nmt_state_o;
    logic [7:0]  nmt_node_o, exp_b0 = 8'h00;
    logic [11:0] last_nmt;
    int          num_errors = 0, tests_run = 0, n_emcy = 0, n_nmt = 0, n_tx = 0, n_rn = 0, n_rc = 0, n_init = 0;

    gcw_if gcw_if_inst ();
    gcw_controller gcw_controller_inst (.core_clk_i, .rst_n_i, .link(gcw_if_inst), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    gcw_device gcw_device_inst (.core_clk_i, .rst_n_i, .link(gcw_if_inst), .role_master_i, .sec_op_req_i,
        .node_st_wr_i, .node_st_idx_i, .node_st_val_i, .node_sup_i, .can_status_i, .err_node_i, .sec_rx_data_i,
        .sec_rx_valid_i, .nmt_state_o, .plc_enabled_o, .nmt_cmd_valid_o, .nmt_cmd_o, .nmt_node_o, .emcy_valid_o,
        .emcy_code_o, .reset_node_o, .reset_comm_o, .sec_tx_data_o, .sec_tx_valid_o);
    gcw_monitor gcw_monitor_inst (.core_clk_i, .rst_n_i, .ctrl_word(gcw_if_inst.ctrl_word),
        .status_word(gcw_if_inst.status_word), .io_out_valid(gcw_if_inst.io_out_valid),
        .io_in_valid(gcw_if_inst.io_in_valid));

    always #25 core_clk_i = ~core_clk_i;

    // Event counters for the one-cycle outputs of the gateway
    always @(posedge core_clk_i) begin
        n_emcy += int'(emcy_valid_o);
        n_nmt += int'(nmt_cmd_valid_o);
        n_tx += int'(sec_tx_valid_o);
        n_rn += int'(reset_node_o);
        n_rc += int'(reset_comm_o);
        n_init += int'(rst_n_i && nmt_state_o == 2'h0);
        if (emcy_valid_o) chk("emcy code", 32'h0000FF10, emcy_code_o);
        if (nmt_cmd_valid_o) last_nmt = {nmt_cmd_o, nmt_node_o};
        if (sec_tx_valid_o) last_tx = sec_tx_data_o;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic send(input logic [7:0] nd, input logic [2:0] c, input logic [3:0] e, input logic [3:0] rs,
                        input logic echo);
        exp_tog = ~exp_tog;
        exp_b0 = echo ? {exp_tog, c, rs} : {exp_tog, exp_b0[6:0]};
        apb(1'b1, ADDR_CMD, {16'h0, nd, 1'b0, c, e});
        repeat (5) @(posedge core_clk_i);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status word", {8'h05, exp_b0}, rd[15:0]);
    endtask : send

    task automatic strobe(input int k, input logic [15:0] d);
        @(posedge core_clk_i);
        sec_op_req_i <= k == 0;
        node_st_wr_i <= k == 1;
        sec_rx_valid_i <= k == 2;
        {node_sup_i, node_st_val_i, node_st_idx_i} <= d[11:0];
        sec_rx_data_i <= d;
        @(posedge core_clk_i);
        {sec_op_req_i, node_st_wr_i, sec_rx_valid_i} <= 3'h0;
        repeat (3) @(posedge core_clk_i);
    endtask : strobe

    task automatic t_start();
        chk("state after start", 32'h1, nmt_state_o);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status at start", 32'h0500, rd[15:0]);
        $display("test start done");
    endtask : t_start

    task automatic t_slave();
        int e;
        int t;
        e = n_emcy;
        strobe(0, 16'h0);
        chk("refused request", e + 1, n_emcy);
        chk("state refused", 32'h1, nmt_state_o);
        send(8'h00, 3'h0, 4'h1, 4'h1, 1'b1);
        chk("state oper", 32'h3, nmt_state_o);
        apb(1'b1, ADDR_IO_OUT, 32'h1234);
        repeat (3) @(posedge core_clk_i);
        chk("tx word", 32'h1234, last_tx);
        strobe(2, 16'hBEEF);
        apb(1'b0, ADDR_IO_IN, 32'h0);
        chk("rx word", 32'h0001BEEF, rd);
        apb(1'b0, ADDR_IO_IN, 32'h0);
        chk("rx fresh cleared", 32'h0000BEEF, rd);
        e = n_emcy;
        send(8'h00, 3'h0, 4'h0, 4'h0, 1'b1);
        chk("preop emcy", e + 1, n_emcy);
        chk("state preop", 32'h1, nmt_state_o);
        t = n_tx;
        apb(1'b1, ADDR_IO_OUT, 32'h5555);
        repeat (3) @(posedge core_clk_i);
        chk("tx gated", t, n_tx);
        send(8'h00, 3'h3, 4'h0, 4'h0, 1'b0);
        send(8'h00, 3'h0, 4'h5, 4'h0, 1'b0);
        $display("test slave done");
    endtask : t_slave

    task automatic t_resets();
        int i;
        int r;
        int c;
        i = n_init;
        r = n_rn;
        c = n_rc;
        send(8'h00, 3'h0, 4'h1, 4'h1, 1'b1);
        for (int k = 2; k < 4; k++) begin
            send(8'h00, 3'h0, 4'(k), 4'(k), 1'b1);
        end
        chk("reset node", r + 1, n_rn);
        chk("reset comm", c + 1, n_rc);
        chk("init passes", i + 2, n_init);
        chk("state after reset", 32'h1, nmt_state_o);
        chk("plc cleared", 32'h0, plc_enabled_o);
        $display("test resets done");
    endtask : t_resets

    task automatic t_master();
        logic [7:0] nd [3] = '{8'h80, 8'h02, 8'h80};
        logic [3:0] ex [3] = '{4'h1, 4'h1, 4'h4};
        int m;
        role_master_i <= 1'b1;
        m = n_nmt;
        send(8'h80, 3'h0, 4'h1, 4'h1, 1'b1);
        send(8'h00, 3'h0, 4'h1, 4'h1, 1'b1);
        chk("no remote yet", m, n_nmt);
        for (int k = 0; k < 3; k++) begin
            send(nd[k], 3'h0, ex[k], ex[k], 1'b1);
            chk("remote cmd", {ex[k], nd[k]}, last_nmt);
        end
        chk("remote count", m + 3, n_nmt);
        $display("test master done");
    endtask : t_master

    task automatic t_query();
        strobe(1, 16'h0A05);
        strobe(1, 16'h0086);
        send(8'h05, 3'h1, 4'h0, 4'h4, 1'b1);
        send(8'h06, 3'h1, 4'h0, 4'h5, 1'b1);
        send(8'h80, 3'h1, 4'h0, 4'h4, 1'b1);
        can_status_i <= 4'hA;
        send(8'h00, 3'h2, 4'h0, 4'hA, 1'b1);
        $display("test query done");
    endtask : t_query

    task automatic t_misc();
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, er);
        exp_tog = ~exp_tog;
        apb(1'b1, ADDR_LINK, 32'h1);
        repeat (5) @(posedge core_clk_i);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("offline nop", {exp_tog, 3'h7}, rd[7:4]);
        chk("nop keeps state", 32'h3, nmt_state_o);
        apb(1'b1, ADDR_LINK, 32'h0);
        $display("test misc done");
    endtask : t_misc

    task automatic print_verdict();
        $display("counts: %0d checks, %0d mismatches", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        t_start();
        t_slave();
        t_resets();
        t_master();
        t_query();
        t_misc();
        print_verdict();
    end
endmodule : tb_gateway_control_word_decoder
`default_nettype wire
